// [core/pin_reset_pkg.sv]
`default_nettype none

package pin_reset_pkg;

  // ----------------------------------------------------------------
  // Pin counts and flat pin numbering
  // ----------------------------------------------------------------
  // Port 0 takes pins 0..31, port 1 pins 32..51 and port 2 pins 52..71.
  localparam int unsigned PIN_COUNT = 72;
  localparam int unsigned PIN_COUNT_SMALL = 38;
  localparam int unsigned IDX_W = 7;
  localparam int unsigned PORT1_BASE = 32;

  // Debug-port pins: port 1 bits 19..16 and port 0 bit 13.
  localparam int unsigned DBG_CLK_IN_PIN = PORT1_BASE + 16;
  localparam int unsigned DBG_MODE_PIN = PORT1_BASE + 17;
  localparam int unsigned DBG_SIN_PIN = PORT1_BASE + 18;
  localparam int unsigned DBG_SOUT_PIN = PORT1_BASE + 19;
  localparam int unsigned DBG_RCLK_PIN = 13;

  // Boot select inputs, the input-only wake-up pin and serial memory pins.
  localparam int unsigned BOOT_SEL0_PIN = 0;
  localparam int unsigned BOOT_SEL1_PIN = 11;
  localparam int unsigned WAKEUP_PIN = PORT1_BASE + 15;
  localparam int unsigned SMEM_DOUT_PIN = 7;
  localparam int unsigned SMEM_CLK_PIN = 5;
  localparam int unsigned SMEM_CS0_PIN = 4;
  localparam int unsigned SMEM_DIN_PIN = 6;

  // ----------------------------------------------------------------
  // Pin group masks
  // ----------------------------------------------------------------
  localparam logic [PIN_COUNT-1:0] DEBUG_MASK = 72'h00_000F_0000_0000_2000;
  localparam logic [PIN_COUNT-1:0] SMEM_MASK = 72'h00_0000_0000_0000_00F0;
  localparam logic [PIN_COUNT-1:0] SMEM_IN_MASK = 72'h00_0000_0000_0000_0040;
  // Reset output enables: every pad floats except the returned debug clock.
  localparam logic [PIN_COUNT-1:0] PAD_OE_N_RESET = 72'hFF_FFFF_FFFF_FFFF_DFFF;

  // ----------------------------------------------------------------
  // Timing and boot codes
  // ----------------------------------------------------------------
  // Total flip-flops between the incoming debug clock and its pin.
  localparam int unsigned RESYNC_STAGES = 3;
  // Boot select code {bit 11, bit 0} that selects serial memory boot.
  localparam logic [1:0] SMEM_BOOT_CODE = 2'h1;
  localparam logic [1:0] BOOT_SEL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_IN_FLOAT = 3'b000,
    MODE_IN_PULLUP = 3'b001,
    MODE_IN_PULLDN = 3'b010,
    MODE_OUT_PP = 3'b011,
    MODE_OUT_OD = 3'b100,
    MODE_ALT = 3'b101
  } pin_mode_e;

  localparam pin_mode_e MODE_RESET = MODE_IN_FLOAT;

  typedef enum logic [1:0] {
    BOOT_WAIT = 2'b00,
    BOOT_SAMPLE = 2'b01,
    BOOT_DONE = 2'b10
  } boot_state_e;

  // One pad's drive: data, active-low output enable and pulls.
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
    logic pull_dn;
  } pad_s;

  localparam pad_s PAD_FLOAT = '{out: 1'b0, oe_n: 1'b1, pull_up: 1'b0, pull_dn: 1'b0};

  // Configuration write from software.
  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] index;
    pin_mode_e mode;
  } cfg_write_s;

  // Debug access controller view of its data output.
  typedef struct packed {
    logic shift;
    logic data;
  } tap_out_s;

endpackage

`default_nettype wire

// [core/debug_clock_resync.sv]
`default_nettype none

// Flip-flop chain that carries the incoming debug clock into the AHB clock
// domain. The first stage is read only by the second one.
module debug_clock_resync #(
  parameter int unsigned STAGES = 2
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Asynchronous level in, synchronised level out
  input wire logic async_i,
  output logic sync_o
);

  logic [STAGES-1:0] chain_q;

  // Shift the level along the chain; reset holds every stage low.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], async_i};
    end
  end

  assign sync_o = chain_q[STAGES-1];

endmodule

`default_nettype wire

// [core/port_reset_state_config.sv]

`default_nettype none

module port_reset_state_config #(
  parameter int unsigned NUM_PINS = pin_reset_pkg::PIN_COUNT,
  parameter int unsigned BONDED_PINS = pin_reset_pkg::PIN_COUNT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Pad side
  input wire logic [NUM_PINS-1:0] pin_in_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_n_o,
  output logic [NUM_PINS-1:0] pin_pull_up_o,
  output logic [NUM_PINS-1:0] pin_pull_dn_o,
  output logic [NUM_PINS-1:0] pin_level_o,
  // Software configuration and general-purpose data
  input wire pin_reset_pkg::cfg_write_s cfg_write_i,
  input wire logic [pin_reset_pkg::IDX_W-1:0] cfg_rd_index_i,
  output pin_reset_pkg::pin_mode_e cfg_rd_mode_o,
  input wire logic gp_data_wr_i,
  input wire logic [NUM_PINS-1:0] gp_data_i,
  input wire logic debug_port_disable_i,
  // Peripheral alternate functions
  input wire logic [NUM_PINS-1:0] af_out_i,
  input wire logic [NUM_PINS-1:0] af_oe_i,
  // Debug access controller
  input wire pin_reset_pkg::tap_out_s tap_out_i,
  output logic debug_clock_in_o,
  output logic debug_serial_in_o,
  output logic debug_mode_select_o,
  // Boot logic and standby wake-up
  output logic boot_done_o,
  output logic [1:0] boot_select_o,
  output logic smem_boot_o,
  output logic standby_wakeup_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pin_reset_pkg::pin_mode_e cfg_q [NUM_PINS];
  logic [NUM_PINS-1:0] gp_data_q;
  logic [NUM_PINS-1:0] pin_out_q;
  logic [NUM_PINS-1:0] pin_out_d;
  logic [NUM_PINS-1:0] pin_oe_n_q;
  logic [NUM_PINS-1:0] pin_oe_n_d;
  logic [NUM_PINS-1:0] pin_pull_up_q;
  logic [NUM_PINS-1:0] pin_pull_up_d;
  logic [NUM_PINS-1:0] pin_pull_dn_q;
  logic [NUM_PINS-1:0] pin_pull_dn_d;
  logic [NUM_PINS-1:0] pin_level_q;
  logic [NUM_PINS-1:0] smem_hold_q;
  logic [NUM_PINS-1:0] smem_hold_d;
  logic [NUM_PINS-1:0] cfg_hit;
  pin_reset_pkg::pin_mode_e cfg_rd_mode_q;
  pin_reset_pkg::pin_mode_e cfg_rd_mode_d;
  pin_reset_pkg::boot_state_e boot_state_q;
  pin_reset_pkg::boot_state_e boot_state_d;
  logic [1:0] boot_select_q;
  logic [1:0] boot_select_d;
  logic boot_done_q;
  logic smem_boot_q;
  logic debug_clock_in_q;
  logic debug_serial_in_q;
  logic debug_mode_select_q;
  logic standby_wakeup_q;
  logic debug_active;
  logic rclk_sync;
  logic cfg_wr_ok;
  logic cfg_rd_ok;
  logic boot_sampling;
  logic smem_selected;

  // ----------------------------------------------------------------
  // Pad drive decoding
  // ----------------------------------------------------------------
  // Turns a software pin mode into a pad drive; the open-drain output only
  // ever pulls low and floats for a one.
  function automatic pin_reset_pkg::pad_s pad_from_mode(
    input pin_reset_pkg::pin_mode_e mode,
    input logic gp_bit,
    input logic af_bit,
    input logic af_en
  );
    pin_reset_pkg::pad_s pad;
    pad = pin_reset_pkg::PAD_FLOAT;
    case (mode)
      pin_reset_pkg::MODE_IN_PULLUP: begin
        pad.pull_up = 1'b1;
      end
      pin_reset_pkg::MODE_IN_PULLDN: begin
        pad.pull_dn = 1'b1;
      end
      pin_reset_pkg::MODE_OUT_PP: begin
        pad.out = gp_bit;
        pad.oe_n = 1'b0;
      end
      pin_reset_pkg::MODE_OUT_OD: begin
        pad.out = 1'b0;
        pad.oe_n = gp_bit;
      end
      pin_reset_pkg::MODE_ALT: begin
        pad.out = af_bit;
        pad.oe_n = ~af_en;
      end
      default: begin
        pad = pin_reset_pkg::PAD_FLOAT;
      end
    endcase
    return pad;
  endfunction

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  // Debug pins stay with the debug port until software disables it.
  assign debug_active = ~debug_port_disable_i;
  assign cfg_wr_ok = cfg_write_i.valid && (int'(cfg_write_i.index) < NUM_PINS);
  assign cfg_rd_ok = int'(cfg_rd_index_i) < NUM_PINS;
  assign cfg_rd_mode_d = cfg_rd_ok ? cfg_q[cfg_rd_index_i] : pin_reset_pkg::MODE_RESET;
  assign boot_sampling = boot_state_q == pin_reset_pkg::BOOT_SAMPLE;
  assign boot_select_d = {pin_in_i[pin_reset_pkg::BOOT_SEL1_PIN],
                          pin_in_i[pin_reset_pkg::BOOT_SEL0_PIN]};
  assign smem_selected = boot_select_d == pin_reset_pkg::SMEM_BOOT_CODE;

  // Returned debug clock: two stages here, the pad flip-flop is the third.
  debug_clock_resync #(
    .STAGES(pin_reset_pkg::RESYNC_STAGES - 1)
  ) u_rclk_resync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pin_in_i[pin_reset_pkg::DBG_CLK_IN_PIN]),
    .sync_o(rclk_sync)
  );

  // ----------------------------------------------------------------
  // Per-pin pad selection
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pin_reset_pkg::pad_s sw_pad;
    pin_reset_pkg::pad_s pad;
    logic is_debug;
    logic is_smem;

    // Software view of the pin; the mode registers steer debug pins only while the debug port is disabled.
    assign sw_pad = pad_from_mode(cfg_q[i], gp_data_q[i], af_out_i[i], af_oe_i[i]);
    assign is_debug = pin_reset_pkg::DEBUG_MASK[i] && debug_active;
    assign is_smem = smem_hold_q[i];
    assign cfg_hit[i] = cfg_wr_ok && (int'(cfg_write_i.index) == i);
    // A boot-time set wins over a software write in the same cycle.
    assign smem_hold_d[i] = (boot_sampling && smem_selected && pin_reset_pkg::SMEM_MASK[i])
                            || (smem_hold_q[i] && !cfg_hit[i]);

    // Priority: unbonded or input-only pin, debug port, serial boot, software.
    always_comb begin
      pad = pin_reset_pkg::PAD_FLOAT;
      if ((i >= BONDED_PINS) || (i == pin_reset_pkg::WAKEUP_PIN)) begin
        pad = pin_reset_pkg::PAD_FLOAT;
        pad.pull_up = (i == pin_reset_pkg::WAKEUP_PIN) ? sw_pad.pull_up : 1'b0;
        pad.pull_dn = (i == pin_reset_pkg::WAKEUP_PIN) ? sw_pad.pull_dn : 1'b0;
      end else if (is_debug) begin
        if (i == pin_reset_pkg::DBG_SOUT_PIN) begin
          pad.out = tap_out_i.data;
          pad.oe_n = ~tap_out_i.shift;
        end else if (i == pin_reset_pkg::DBG_RCLK_PIN) begin
          pad.out = rclk_sync;
          pad.oe_n = 1'b0;
        end else begin
          pad = pin_reset_pkg::PAD_FLOAT;
        end
      end else if (is_smem) begin
        pad.out = af_out_i[i];
        pad.oe_n = pin_reset_pkg::SMEM_IN_MASK[i];
      end else begin
        pad = sw_pad;
      end
    end

    assign pin_out_d[i] = pad.out;
    assign pin_oe_n_d[i] = pad.oe_n;
    assign pin_pull_up_d[i] = pad.pull_up;
    assign pin_pull_dn_d[i] = pad.pull_dn;
  end

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  // Every pin, debug pins included, resets to the same floating input mode.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < NUM_PINS; k++) begin
        cfg_q[k] <= pin_reset_pkg::MODE_RESET;
      end
    end else if (cfg_wr_ok) begin
      cfg_q[cfg_write_i.index] <= cfg_write_i.mode;
    end
  end

  // General-purpose output data and configuration read-back.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gp_data_q <= '0;
      cfg_rd_mode_q <= pin_reset_pkg::MODE_RESET;
    end else begin
      gp_data_q <= gp_data_wr_i ? gp_data_i : gp_data_q;
      cfg_rd_mode_q <= cfg_rd_mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Pad registers
  // ----------------------------------------------------------------
  // Reset floats every pad but the returned clock, which is driven low
  // throughout reset so the probe never sees a floating clock.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_out_q <= '0;
      pin_oe_n_q <= pin_reset_pkg::PAD_OE_N_RESET[NUM_PINS-1:0];
      pin_pull_up_q <= '0;
      pin_pull_dn_q <= '0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
      pin_pull_up_q <= pin_pull_up_d;
      pin_pull_dn_q <= pin_pull_dn_d;
    end
  end

  // Serial memory boot hold, cleared per pin by software reconfiguration.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      smem_hold_q <= '0;
    end else begin
      smem_hold_q <= smem_hold_d;
    end
  end

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  // Pin levels for software and peripherals, and debug inputs to the TAP.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_level_q <= '0;
      debug_clock_in_q <= 1'b0;
      debug_serial_in_q <= 1'b0;
      debug_mode_select_q <= 1'b0;
      standby_wakeup_q <= 1'b0;
    end else begin
      pin_level_q <= pin_in_i;
      debug_clock_in_q <= pin_in_i[pin_reset_pkg::DBG_CLK_IN_PIN];
      debug_serial_in_q <= pin_in_i[pin_reset_pkg::DBG_SIN_PIN];
      debug_mode_select_q <= pin_in_i[pin_reset_pkg::DBG_MODE_PIN];
      standby_wakeup_q <= pin_in_i[pin_reset_pkg::WAKEUP_PIN];
    end
  end

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  // Waits one cycle after release, samples the selects, then lets the
  // processor fetch from address zero.
  always_comb begin
    boot_state_d = boot_state_q;
    case (boot_state_q)
      pin_reset_pkg::BOOT_WAIT: begin
        boot_state_d = pin_reset_pkg::BOOT_SAMPLE;
      end
      pin_reset_pkg::BOOT_SAMPLE: begin
        boot_state_d = pin_reset_pkg::BOOT_DONE;
      end
      pin_reset_pkg::BOOT_DONE: begin
        boot_state_d = pin_reset_pkg::BOOT_DONE;
      end
      default: begin
        boot_state_d = pin_reset_pkg::BOOT_WAIT;
      end
    endcase
  end

  // Boot state, captured selects and the fetch release flag.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      boot_state_q <= pin_reset_pkg::BOOT_WAIT;
      boot_select_q <= pin_reset_pkg::BOOT_SEL_RESET;
      boot_done_q <= 1'b0;
      smem_boot_q <= 1'b0;
    end else begin
      boot_state_q <= boot_state_d;
      boot_select_q <= boot_sampling ? boot_select_d : boot_select_q;
      smem_boot_q <= boot_sampling ? smem_selected : smem_boot_q;
      boot_done_q <= boot_sampling || boot_done_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pin_out_o = pin_out_q;
  assign pin_oe_n_o = pin_oe_n_q;
  assign pin_pull_up_o = pin_pull_up_q;
  assign pin_pull_dn_o = pin_pull_dn_q;
  assign pin_level_o = pin_level_q;
  assign cfg_rd_mode_o = cfg_rd_mode_q;
  assign debug_clock_in_o = debug_clock_in_q;
  assign debug_serial_in_o = debug_serial_in_q;
  assign debug_mode_select_o = debug_mode_select_q;
  assign boot_done_o = boot_done_q;
  assign boot_select_o = boot_select_q;
  assign smem_boot_o = smem_boot_q;
  assign standby_wakeup_o = standby_wakeup_q;

endmodule

`default_nettype wire

// [verification/pin_reset_sva.sv]
`default_nettype none

// Watches the pad, debug and boot ports of the port reset block.
module pin_reset_sva #(
  parameter int unsigned NUM_PINS = 72
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Pads
  input wire logic [NUM_PINS-1:0] pin_in_i,
  input wire logic [NUM_PINS-1:0] pin_out_o,
  input wire logic [NUM_PINS-1:0] pin_oe_n_o,
  input wire logic [NUM_PINS-1:0] pin_pull_up_o,
  // Control and status
  input wire pin_reset_pkg::cfg_write_s cfg_write_i,
  input wire logic debug_port_disable_i,
  input wire pin_reset_pkg::tap_out_s tap_out_i,
  input wire logic boot_done_o,
  input wire logic [1:0] boot_select_o,
  input wire logic smem_boot_o
);
  // Edges since reset release, saturating, so history checks start clean.
  logic [2:0] run_q;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_q <= 3'h0;
    end else if (run_q != 3'h7) begin
      run_q <= run_q + 3'h1;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_rclk_reset_low: assert property ($fell(sys_rst_i) |-> !pin_out_o[13])
    else $error("returned clock not low at reset exit");
  a_rclk_driven: assert property (!$past(debug_port_disable_i) |-> !pin_oe_n_o[13])
    else $error("returned clock pad not driven");
  a_rclk_resync: assert property (run_q >= 3'h3 && !$past(debug_port_disable_i)
    |-> pin_out_o[13] == $past(pin_in_i[48], 3))
    else $error("returned clock not three flops behind");
  a_dout_follows_shift: assert property (run_q >= 3'h1 && !$past(debug_port_disable_i)
    |-> pin_oe_n_o[51] == !$past(tap_out_i.shift))
    else $error("debug data out enable wrong");
  a_din_floats: assert property (run_q >= 3'h1 && !$past(debug_port_disable_i)
    |-> &pin_oe_n_o[50:48])
    else $error("debug input pad driven");
  a_boot_timing: assert property ($fell(sys_rst_i)
    |-> !boot_done_o ##1 !boot_done_o ##1 boot_done_o[*3])
    else $error("boot done timing wrong");
  a_boot_sample: assert property ($fell(sys_rst_i) |-> ##2
    (boot_select_o[0] == $past(pin_in_i[0]) && boot_select_o[1] == $past(pin_in_i[11])))
    else $error("boot pins not sampled");
  a_smem_pads: assert property ($fell(sys_rst_i) ##2 smem_boot_o
    |-> ##1 (pin_oe_n_o[7:4] == 4'h4 && &pin_oe_n_o[12:10]))
    else $error("serial boot pads wrong");
  a_smem_code: assert property (boot_done_o
    |-> smem_boot_o == (boot_select_o == pin_reset_pkg::SMEM_BOOT_CODE))
    else $error("serial boot decode wrong");
  a_wakeup_no_drive: assert property (pin_oe_n_o[47])
    else $error("wake-up pin driven");
  a_cfg_pullup: assert property (cfg_write_i.valid && cfg_write_i.index == 7'h14
    && cfg_write_i.mode == pin_reset_pkg::MODE_IN_PULLUP |-> ##2 pin_pull_up_o[20])
    else $error("pull-up write not applied");
endmodule

`default_nettype wire

// [verification/pad_world.sv]
`default_nettype none

// Board around the pads: straps, debug probe clock and floating wires.
module pad_world (
  // Clock
  input wire logic ref_clk_i,
  // Pad drive from the block
  input wire logic [71:0] out_i,
  input wire logic [71:0] oe_n_i,
  input wire logic [71:0] pu_i,
  input wire logic [71:0] pd_i,
  // External drivers
  input wire logic [71:0] ext_en_i,
  input wire logic [71:0] ext_val_i,
  input wire logic tck_run_i,
  // Resolved pin levels
  output logic [71:0] pin_o
);
  localparam logic [71:0] PROBE = 72'h00_0001_0000_0000_0000;
  logic [71:0] noise_q = {36{2'h2}};
  logic tck_q = 1'b0;
  logic [71:0] ext_w;
  logic [71:0] own_w;

  // A floating wire wanders each cycle; the probe clock stops between scans.
  always_ff @(posedge ref_clk_i) begin
    noise_q <= ~noise_q;
    if (tck_run_i) begin
      tck_q <= ~tck_q;
    end
  end

  // Block drive wins, then probe and straps, then pulls, else noise.
  assign own_w = ext_en_i | PROBE;
  assign ext_w = {ext_val_i[71:49], tck_q, ext_val_i[47:0]};
  assign pin_o = (~oe_n_i & out_i)
    | (oe_n_i & ((own_w & ext_w) | (~own_w & (pu_i | (~pd_i & noise_q)))));
endmodule

`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [71:0] pin_in_i, pin_out_o, pin_oe_n_o, pin_pull_up_o, pin_pull_dn_o, pin_level_o;
  pin_reset_pkg::cfg_write_s cfg_write_i = '0;
  logic [6:0] cfg_rd_index_i = 7'h14;
  pin_reset_pkg::pin_mode_e cfg_rd_mode_o;
  logic gp_data_wr_i = 1'b0;
  logic [71:0] gp_data_i = '0;
  logic debug_port_disable_i = 1'b0;
  logic [71:0] af_out_i = '0;
  logic [71:0] af_oe_i = '0;
  pin_reset_pkg::tap_out_s tap_out_i = '0;
  logic debug_clock_in_o, debug_serial_in_o, debug_mode_select_o;
  logic boot_done_o, smem_boot_o, standby_wakeup_o;
  logic [1:0] boot_select_o;
  logic [71:0] ext_en = 72'h00_0006_8000_0000_0801;
  logic [71:0] ext_val = 72'h00_0002_8000_0000_0000;
  logic tck_run = 1'b0;
  int n_mismatch = 0;
  int num_checks = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  port_reset_state_config dut (.ref_clk_i, .sys_rst_i, .pin_in_i, .pin_out_o,
    .pin_oe_n_o, .pin_pull_up_o, .pin_pull_dn_o, .pin_level_o, .cfg_write_i,
    .cfg_rd_index_i, .cfg_rd_mode_o, .gp_data_wr_i, .gp_data_i, .debug_port_disable_i,
    .af_out_i, .af_oe_i, .tap_out_i, .debug_clock_in_o, .debug_serial_in_o,
    .debug_mode_select_o, .boot_done_o, .boot_select_o, .smem_boot_o, .standby_wakeup_o);

  pad_world board (.ref_clk_i, .out_i(pin_out_o), .oe_n_i(pin_oe_n_o),
    .pu_i(pin_pull_up_o), .pd_i(pin_pull_dn_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .tck_run_i(tck_run), .pin_o(pin_in_i));

  // ----------------------------------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [71:0] got, input logic [71:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Writes one pin mode; returns once the pad has taken it.
  task automatic wr_cfg(input int unsigned idx, input pin_reset_pkg::pin_mode_e m);
    cfg_write_i.valid = 1'b1;
    cfg_write_i.index = 7'(idx);
    cfg_write_i.mode = m;
    @(negedge ref_clk_i);
    cfg_write_i.valid = 1'b0;
    @(negedge ref_clk_i);
  endtask

  // Resets with the given {pin 11, pin 0} straps and waits for boot.
  task automatic do_reset(input logic [1:0] strap);
    int n;
    n = 0;
    sys_rst_i = 1'b1;
    ext_val[11] = strap[1];
    ext_val[0] = strap[0];
    repeat (12) @(negedge ref_clk_i);
    chk_vec(pin_oe_n_o, ~(72'h1 << 13), "reset oe");
    chk_vec(pin_pull_up_o | pin_pull_dn_o, '0, "reset pulls");
    chk_bit(pin_out_o[13], 1'b0, "rclk in reset");
    sys_rst_i = 1'b0;
    while (boot_done_o !== 1'b1 && n < 8) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 8) begin
      n_mismatch++;
      $display("BAD %0t boot never done", $time);
      results();
    end
    repeat (2) @(negedge ref_clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_plain();
    do_reset(2'h2);
    chk_vec(pin_oe_n_o, ~(72'h1 << 13), "idle oe");
    chk_vec(72'(boot_select_o), 72'h2, "boot select");
    chk_bit(smem_boot_o, 1'b0, "no serial boot");
    chk_vec(pin_level_o & ext_en, pin_in_i & ext_en, "pin levels");
    cfg_rd_index_i = 7'h31;
    @(negedge ref_clk_i);
    chk_vec(72'(cfg_rd_mode_o), 72'(pin_reset_pkg::MODE_RESET), "debug cfg reset");
    cfg_rd_index_i = 7'h14;
  endtask

  task automatic t_cfg_modes();
    logic [2:0] exp [6] = '{3'h4, 3'h6, 3'h5, 3'h0, 3'h4, 3'h0};
    gp_data_i[20] = 1'b1;
    gp_data_wr_i = 1'b1;
    af_out_i[20] = 1'b1;
    af_oe_i[20] = 1'b1;
    @(negedge ref_clk_i);
    gp_data_wr_i = 1'b0;
    for (int m = 0; m < 6; m++) begin
      wr_cfg(20, pin_reset_pkg::pin_mode_e'(m));
      chk_vec(72'({pin_oe_n_o[20], pin_pull_up_o[20], pin_pull_dn_o[20]}), 72'(exp[m]),
        "mode pads");
      chk_vec(72'(cfg_rd_mode_o), 72'(m), "mode read");
      if (!exp[m][2]) begin
        chk_bit(pin_out_o[20], 1'b1, "mode drive");
      end
    end
    wr_cfg(20, pin_reset_pkg::MODE_IN_FLOAT);
  endtask

  task automatic t_debug();
    wr_cfg(49, pin_reset_pkg::MODE_OUT_PP);
    chk_vec(72'(pin_oe_n_o[51:48]), 72'hf, "debug pads float");
    chk_bit(debug_mode_select_o, 1'b1, "mode select in");
    chk_bit(debug_serial_in_o, 1'b0, "serial in");
    tap_out_i = '{shift: 1'b1, data: 1'b1};
    @(negedge ref_clk_i);
    chk_bit(pin_oe_n_o[51], 1'b0, "dout driven");
    chk_bit(pin_out_o[51], 1'b1, "dout data");
    tap_out_i = '{shift: 1'b0, data: 1'b1};
    @(negedge ref_clk_i);
    chk_bit(pin_oe_n_o[51], 1'b1, "dout idle");
    debug_port_disable_i = 1'b1;
    @(negedge ref_clk_i);
    chk_bit(pin_oe_n_o[49], 1'b0, "debug pin as gpio");
    debug_port_disable_i = 1'b0;
    @(negedge ref_clk_i);
    chk_bit(pin_oe_n_o[49], 1'b1, "debug pin back");
    wr_cfg(49, pin_reset_pkg::MODE_IN_FLOAT);
  endtask

  task automatic t_rclk();
    for (int k = 0; k < 2; k++) begin
      tck_run = 1'b1;
      repeat (7) @(negedge ref_clk_i);
      tck_run = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      chk_bit(pin_out_o[13], pin_in_i[48], "rclk level");
      chk_bit(debug_clock_in_o, pin_in_i[48], "debug clock in");
      chk_bit(pin_oe_n_o[13], 1'b0, "rclk driven");
    end
  endtask

  task automatic t_wakeup();
    wr_cfg(47, pin_reset_pkg::MODE_OUT_PP);
    chk_bit(pin_oe_n_o[47], 1'b1, "wake-up not driven");
    chk_bit(standby_wakeup_o, 1'b1, "wake-up in");
    wr_cfg(47, pin_reset_pkg::MODE_IN_PULLUP);
    chk_bit(pin_pull_up_o[47], 1'b1, "wake-up pull");
    wr_cfg(47, pin_reset_pkg::MODE_IN_FLOAT);
  endtask

  task automatic t_smem_boot();
    af_out_i[7:4] = 4'ha;
    do_reset(2'h1);
    chk_bit(smem_boot_o, 1'b1, "serial boot");
    chk_vec(72'(pin_oe_n_o[12:4]), 72'h1f4, "serial pads oe");
    chk_vec(72'(pin_out_o[7:4] & 4'hb), 72'ha, "serial pads out");
    wr_cfg(6, pin_reset_pkg::MODE_OUT_PP);
    chk_bit(pin_oe_n_o[6], 1'b0, "serial pin reconfig");
  endtask

  // Main sequence.
  initial begin
    t_plain();
    t_cfg_modes();
    t_debug();
    t_rclk();
    t_wakeup();
    t_smem_boot();
    results();
  end
endmodule

bind port_reset_state_config pin_reset_sva #(.NUM_PINS(NUM_PINS)) u_sva (.ref_clk_i,
  .sys_rst_i, .pin_in_i, .pin_out_o, .pin_oe_n_o, .pin_pull_up_o, .cfg_write_i,
  .debug_port_disable_i, .tap_out_i, .boot_done_o, .boot_select_o, .smem_boot_o);

`default_nettype wire
